// ==== eeprom_regs.svh ====
// constants of the serial eeprom access core
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// ***************
// opcodes
// ***************
`define READ_CMD 8'h03
`define WRITE_CMD 8'h02
`define LATCH_SET_CMD 8'h06
`define LATCH_CLEAR_CMD 8'h04
`define STATUS_READ_CMD 8'h05
`define STATUS_WRITE_CMD 8'h01

// ***************
// array geometry
// ***************
`define ADDR_BITS 10
`define PAGE_BITS 5
`define PAGE_BYTES 32
`define ADDR_BYTES 2
`define LAST_BIT 3'h7
`define PAGE_REFRESH 1'b0
`define WP_CLEARS_LATCH 1'b0

// ***************
// status layout
// ***************
`define ST_PIN_EN 7
`define ST_BP_HI 3
`define ST_BP_LO 2
`define ST_LATCH 1
`define ST_BUSY 0
`define RST_PIN_EN 1'b0
`define RST_BP_HI 1'b0
`define RST_BP_LO 1'b0

// ***************
// timing
// ***************
`define WRITE_TIME_US 5000
`define MCLK_MHZ 50
`define FIFO_DEPTH 16

`endif

// ==== eeprom_pkg.sv ====
// types of the serial eeprom access core
package eeprom_pkg;
  `include "eeprom_regs.svh"

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } pin_sample_t;

  typedef struct packed {
    logic [`PAGE_BITS-1:0] col;
    logic [7:0] data;
  } page_word_t;

  typedef enum logic [3:0] {
    st_idle, st_cmd, st_addr, st_read, st_write, st_status, st_lset_done, st_lclr_done,
    st_ignore
  } phase_t;

  typedef enum logic [1:0] {
    pg_idle, pg_drain, pg_prog, pg_wait
  } prog_t;
endpackage : eeprom_pkg

// ==== spi_eeprom_access_core.sv ====
// fifo and serial eeprom access core
`timescale 1ns/100ps

// ***************
// fifo
// ***************
module page_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = store[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : page_fifo

// ***************
// access core
// ***************
// Overview of operation
// - after select, read opcode and address return the stored byte on serial out
// - each byte shifted out advances the read pointer by one
// - pointer wraps from highest address to zero, reads never stop
// - chip select rising ends a read at once
// - latch sets only on chip select rising right after the lone opcode
// - further bits after latch-set opcode in one select cancel the latch set
// - each write cycle erases targeted bytes itself before programming
// - write opcode, address, then one to a page of bytes within one page
// - write column wraps inside the page, never into the next
// - largest densities refresh the whole page on every write cycle; here PAGE_REFRESH is 0, so only targeted bytes are written
// - write starts only when select rises on a byte boundary, else abandoned
// - array access refused while a write cycle runs
// - latch clears when a write cycle finishes
// - latch-set opcode sets, latch-clear opcode clears; no write without latch
// - latch clears at reset, latch-clear, write, and low protect pin on small parts; WP_CLEARS_LATCH is 0 here, so the pin never clears it
// - status readable any time, also during a write cycle
// - status: pin enable, three zeros, protect hi, protect lo, latch, busy
// - busy flag is one only while a write cycle runs
// - latch flag mirrors the latch, updated by set and clear opcodes only when each stands alone in its select
// - block protect bits never change after reset; status write opcode is not decoded
// - opcode values read 03, write 02, set 06, clear 04, status 05, 01
// - input sampled on rising clock, msb first
module spi_eeprom_access_core
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = `WRITE_TIME_US * `MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe
);
  logic [7:0] mem [2**`ADDR_BITS];
  logic [7:0] pbuf [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] pmask_reg;
  pin_sample_t meta_reg;
  pin_sample_t sync_reg;
  pin_sample_t last_reg;
  phase_t state_reg;
  prog_t prog_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] out_cnt_reg;
  logic [7:0] rx_next;
  logic [7:0] tx_reg;
  logic [15:0] addr_sh_reg;
  logic [0:0] addr_cnt_reg;
  logic [`ADDR_BITS-1:0] rd_ptr_reg;
  logic [`ADDR_BITS-1:0] rd_ptr_next;
  logic [`ADDR_BITS-`PAGE_BITS-1:0] page_reg;
  logic [`PAGE_BITS-1:0] col_reg;
  logic [`PAGE_BITS-1:0] prog_idx_reg;
  logic [17:0] wait_cnt_reg;
  logic got_byte_reg;
  logic overflow_reg;
  logic latch_reg;
  logic pin_en_reg;
  logic bp_hi_reg;
  logic bp_lo_reg;
  logic active;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic wp_fall;
  logic byte_done;
  logic addr_done;
  logic write_start;
  logic commit;
  logic prog_done;
  logic busy;
  page_word_t fifo_in;
  page_word_t fifo_out;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [`ADDR_BITS-1:0] addr_masked;
  logic tx_is_read;
  logic tx_is_read_reg;

  function automatic logic [7:0] status_byte(input logic pe, input logic hi, input logic lo,
                                             input logic lt, input logic bz);
    logic [7:0] s;
    s = 8'h00;
    s[`ST_PIN_EN] = pe;
    s[`ST_BP_HI] = hi;
    s[`ST_BP_LO] = lo;
    s[`ST_LATCH] = lt;
    s[`ST_BUSY] = bz;
    return s;
  endfunction : status_byte

  // ***************
  // pin synchronisers and edges
  // ***************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      sync_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      last_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end else begin
      meta_reg <= '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign active = !sync_reg.cs_n && sync_reg.hold_n;
  assign sck_rise = active && sync_reg.sck && !last_reg.sck;
  assign sck_fall = active && !sync_reg.sck && last_reg.sck;
  assign cs_fall = !sync_reg.cs_n && last_reg.cs_n;
  assign cs_rise = sync_reg.cs_n && !last_reg.cs_n;
  assign wp_fall = !sync_reg.wp_n && last_reg.wp_n;
  assign rx_next = {addr_sh_reg[6:0], sync_reg.si};
  assign byte_done = sck_rise && (bit_cnt_reg == `LAST_BIT);
  assign addr_done = byte_done && (state_reg == st_addr) &&
                     (addr_cnt_reg == 1'(`ADDR_BYTES - 1));
  assign addr_masked = {addr_sh_reg[`ADDR_BITS-2:7], rx_next};
  assign write_start = addr_done && (state_reg == st_addr) && !tx_is_read;
  assign busy = (prog_reg != pg_idle);
  assign commit = cs_rise && (state_reg == st_write) && (bit_cnt_reg == 3'h0) &&
                  got_byte_reg && latch_reg && !overflow_reg;
  assign rd_ptr_next = rd_ptr_reg + 1'b1;

  assign tx_is_read = tx_is_read_reg;

  // ***************
  // command sequencer
  // ***************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= st_idle;
      bit_cnt_reg <= 3'h0;
      addr_sh_reg <= 16'h0000;
      addr_cnt_reg <= 1'b0;
      tx_is_read_reg <= 1'b0;
    end else if (cs_rise || sync_reg.cs_n) begin
      state_reg <= st_idle;
      bit_cnt_reg <= 3'h0;
    end else if (cs_fall) begin
      state_reg <= st_cmd;
      bit_cnt_reg <= 3'h0;
      addr_cnt_reg <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      addr_sh_reg <= {addr_sh_reg[14:0], sync_reg.si};
      case (state_reg)
        st_cmd: begin
          if (byte_done) begin
            case (rx_next)
              `READ_CMD: begin
                state_reg <= busy ? st_ignore : st_addr;
                tx_is_read_reg <= 1'b1;
              end
              `WRITE_CMD: begin
                state_reg <= busy ? st_ignore : st_addr;
                tx_is_read_reg <= 1'b0;
              end
              `LATCH_SET_CMD: state_reg <= st_lset_done;
              `LATCH_CLEAR_CMD: state_reg <= st_lclr_done;
              `STATUS_READ_CMD: state_reg <= st_status;
              default: state_reg <= st_ignore;
            endcase
          end
        end
        st_addr: begin
          if (byte_done) begin
            addr_cnt_reg <= addr_cnt_reg + 1'b1;
            if (addr_done) begin
              state_reg <= tx_is_read_reg ? st_read : st_write;
            end
          end
        end
        st_lset_done: state_reg <= st_ignore;
        st_lclr_done: state_reg <= st_ignore;
        st_read: state_reg <= st_read;
        st_write: state_reg <= st_write;
        st_status: state_reg <= st_status;
        st_ignore: state_reg <= st_ignore;
        default: state_reg <= st_ignore;
      endcase
    end
  end

  // ***************
  // write data collection
  // ***************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      page_reg <= '0;
      col_reg <= '0;
      got_byte_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else if (write_start) begin
      page_reg <= addr_masked[`ADDR_BITS-1:`PAGE_BITS];
      col_reg <= addr_masked[`PAGE_BITS-1:0];
      got_byte_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else if (byte_done && state_reg == st_write) begin
      col_reg <= col_reg + 1'b1;
      got_byte_reg <= 1'b1;
      if (!fifo_in_ready) begin
        overflow_reg <= 1'b1;
      end
    end
  end

  assign fifo_in = '{col: col_reg, data: rx_next};
  assign fifo_in_valid = byte_done && (state_reg == st_write);
  assign fifo_out_ready = (prog_reg != pg_prog);

  page_fifo #(
    .WIDTH($bits(page_word_t)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_data(fifo_in),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // ***************
  // page buffer
  // ***************
  always_ff @(posedge mclk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      pbuf[fifo_out.col] <= fifo_out.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pmask_reg <= '0;
    end else if (write_start) begin
      pmask_reg <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      pmask_reg[fifo_out.col] <= 1'b1;
    end
  end

  // ***************
  // self-timed write cycle
  // ***************
  assign prog_done = (prog_reg == pg_wait) && (wait_cnt_reg == 18'(WRITE_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prog_reg <= pg_idle;
      prog_idx_reg <= '0;
      wait_cnt_reg <= '0;
    end else begin
      case (prog_reg)
        pg_idle: begin
          if (commit) begin
            prog_reg <= pg_drain;
          end
        end
        pg_drain: begin
          if (!fifo_out_valid) begin
            prog_reg <= pg_prog;
            prog_idx_reg <= '0;
          end
        end
        pg_prog: begin
          prog_idx_reg <= prog_idx_reg + 1'b1;
          if (prog_idx_reg == `PAGE_BITS'(`PAGE_BYTES - 1)) begin
            prog_reg <= pg_wait;
            wait_cnt_reg <= '0;
          end
        end
        pg_wait: begin
          wait_cnt_reg <= wait_cnt_reg + 1'b1;
          if (prog_done) begin
            prog_reg <= pg_idle;
          end
        end
        default: prog_reg <= pg_idle;
      endcase
    end
  end

  // erase and program of each targeted byte in one step
  always_ff @(posedge mclk) begin
    if (prog_reg == pg_prog && (pmask_reg[prog_idx_reg] || `PAGE_REFRESH)) begin
      mem[{page_reg, prog_idx_reg}] <= pmask_reg[prog_idx_reg] ?
                                        pbuf[prog_idx_reg] : mem[{page_reg, prog_idx_reg}];
    end
  end

  // ***************
  // write enable latch and status bits
  // ***************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      latch_reg <= 1'b0;
    end else if (cs_rise && state_reg == st_lset_done) begin
      latch_reg <= 1'b1;
    end else if (cs_rise && state_reg == st_lclr_done) begin
      latch_reg <= 1'b0;
    end else if (prog_done) begin
      latch_reg <= 1'b0;
    end else if (wp_fall && `WP_CLEARS_LATCH) begin
      latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_en_reg <= `RST_PIN_EN;
      bp_hi_reg <= `RST_BP_HI;
      bp_lo_reg <= `RST_BP_LO;
    end else begin
      pin_en_reg <= pin_en_reg;
      bp_hi_reg <= bp_hi_reg;
      bp_lo_reg <= bp_lo_reg;
    end
  end

  // ***************
  // output shifter
  // ***************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_reg <= 8'h00;
      out_cnt_reg <= 3'h0;
      rd_ptr_reg <= '0;
    end else if (byte_done && state_reg == st_cmd && rx_next == `STATUS_READ_CMD) begin
      tx_reg <= status_byte(pin_en_reg, bp_hi_reg, bp_lo_reg, latch_reg, busy);
      out_cnt_reg <= 3'h0;
    end else if (addr_done && tx_is_read_reg) begin
      rd_ptr_reg <= addr_masked;
      tx_reg <= mem[addr_masked];
      out_cnt_reg <= 3'h0;
    end else if (sck_fall && (state_reg == st_read || state_reg == st_status)) begin
      out_cnt_reg <= out_cnt_reg + 1'b1;
      tx_reg <= {tx_reg[6:0], 1'b0};
      if (out_cnt_reg == `LAST_BIT) begin
        if (state_reg == st_read) begin
          rd_ptr_reg <= rd_ptr_next;
          tx_reg <= mem[rd_ptr_next];
        end else begin
          tx_reg <= status_byte(pin_en_reg, bp_hi_reg, bp_lo_reg, latch_reg, busy);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end else if (!active || !(state_reg == st_read || state_reg == st_status)) begin
      so_oe <= 1'b0;
    end else if (sck_fall) begin
      so_out <= tx_reg[7];
      so_oe <= 1'b1;
    end
  end
endmodule : spi_eeprom_access_core

// ==== spi_eeprom_access_core_assertions.sv ====
// assertion checker for the serial eeprom access core
`timescale 1ns/100ps
module spi_eeprom_access_core_assertions #(
  parameter int WRITE_CYCLES = 250000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_out,
  input wire logic so_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_QUIET_AFTER_RESET: assert property ($rose(rstn) |-> !so_oe && !so_out)
    else $error("serial out active after reset");
  AST_OFF_DESELECTED: assert property (cs_n [*6] |-> !so_oe)
    else $error("serial out enabled while deselected");
  AST_CS_RISE_ENDS: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("serial out not released after select rise");
  AST_OE_NEEDS_SELECT: assert property ($rose(so_oe) |-> !cs_n && $past(!cs_n, 4))
    else $error("serial out enabled without select");
  AST_OE_AFTER_FALL: assert property ($rose(so_oe) |-> $past(!sck, 2))
    else $error("serial out enabled away from clock fall");
  AST_OE_HELD: assert property (so_oe && !cs_n && hold_n |=> so_oe)
    else $error("serial out dropped while selected");
  AST_DROP_CAUSE: assert property ($fell(so_oe) |-> cs_n || !hold_n)
    else $error("serial out dropped without cause");
  AST_SO_STEADY_HIGH: assert property ($rose(sck) && so_oe |-> ##2 $stable(so_out) [*2])
    else $error("serial out changed while clock high");

  cover property ($rose(so_oe));
  cover property ($fell(so_oe));
  cover property (so_oe && $rose(cs_n));
endmodule : spi_eeprom_access_core_assertions

// ==== spi_host_model.sv ====
// host side serial bus controller model
`timescale 1ns/100ps
module spi_host_model (
  input wire logic mclk,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n,
  input wire logic so_out,
  input wire logic so_oe
);
  int slow = 0;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end

  task automatic select();
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : select

  task automatic deselect();
    sck <= 1'b0;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (12) @(posedge mclk);
  endtask : deselect

  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      repeat (4 + slow) @(posedge mclk);
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
      rx[i] = so_oe ? so_out : 1'bz;
    end
  endtask : xfer
endmodule : spi_host_model

// ==== testbench.sv ====
// self-checking testbench for the serial eeprom access core
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module testbench;
  logic mclk;
  logic rstn;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so_out;
  logic so_oe;
  logic [7:0] mem [0:1023];
  logic [7:0] rx;
  int miscompares = 0;
  int checks = 0;

  spi_eeprom_access_core #(.WRITE_CYCLES(400)) i_dut (.mclk(mclk), .rstn(rstn), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe));
  spi_host_model i_host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe));

  // ****
  // helpers
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic cmd(input logic [7:0] op);
    i_host.select();
    i_host.xfer(op, 8, rx);
    i_host.deselect();
  endtask : cmd

  task automatic status_is(input logic [7:0] exp);
    i_host.select();
    i_host.xfer(`STATUS_READ_CMD, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    i_host.deselect();
    check(rx, exp);
  endtask : status_is

  task automatic wait_idle();
    for (int k = 0; k < 20; k++) begin
      i_host.select();
      i_host.xfer(`STATUS_READ_CMD, 8, rx);
      i_host.xfer(8'h00, 8, rx);
      i_host.deselect();
      if (rx[0] === 1'b0) return;
    end
    miscompares++;
    give_verdict();
  endtask : wait_idle

  task automatic write_bytes(input logic [15:0] a, input int n, input logic [7:0] d,
      input bit commit);
    i_host.select();
    i_host.xfer(`WRITE_CMD, 8, rx);
    i_host.xfer(a[15:8], 8, rx);
    i_host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(d + 8'(i), 8, rx);
      if (commit) mem[{a[9:5], 5'(a[4:0] + i)}] = d + 8'(i);
    end
    i_host.deselect();
  endtask : write_bytes

  task automatic read_check(input logic [15:0] a, input int n);
    i_host.select();
    i_host.xfer(`READ_CMD, 8, rx);
    i_host.xfer(a[15:8], 8, rx);
    i_host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'h00, 8, rx);
      check(rx, mem[10'(a[9:0] + i)]);
    end
    i_host.deselect();
  endtask : read_check

  // ****
  // scenarios
  // ****
  task automatic t_idle();
    check({7'h00, so_oe}, 8'h00);
    status_is(8'h00);
    $display("t_idle done");
  endtask : t_idle

  task automatic t_latch();
    cmd(`LATCH_SET_CMD);
    status_is(8'h02);
    cmd(`LATCH_CLEAR_CMD);
    status_is(8'h00);
    i_host.select();
    i_host.xfer(`LATCH_SET_CMD, 8, rx);
    i_host.xfer(`WRITE_CMD, 8, rx);
    i_host.deselect();
    status_is(8'h00);
    $display("t_latch done");
  endtask : t_latch

  task automatic t_write();
    cmd(`LATCH_SET_CMD);
    write_bytes(16'hfc00, 2, 8'ha0, 1'b1);
    status_is(8'h03);
    wait_idle();
    status_is(8'h00);
    cmd(`LATCH_SET_CMD);
    write_bytes(16'h03fe, 4, 8'h50, 1'b1);
    i_host.select();
    i_host.xfer(`READ_CMD, 8, rx);
    i_host.xfer(8'h03, 8, rx);
    i_host.xfer(8'hfe, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    i_host.deselect();
    check(rx, 8'hzz);
    wait_idle();
    read_check(16'h03fe, 4);
    read_check(16'h03e0, 2);
    $display("t_write done");
  endtask : t_write

  task automatic t_abandon();
    i_host.slow = 3;
    cmd(`LATCH_SET_CMD);
    i_host.select();
    i_host.xfer(`WRITE_CMD, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    i_host.xfer(8'h00, 8, rx);
    i_host.xfer(8'h11, 8, rx);
    i_host.xfer(8'h22, 4, rx);
    i_host.deselect();
    status_is(8'h02);
    cmd(`LATCH_CLEAR_CMD);
    write_bytes(16'h0000, 1, 8'h99, 1'b0);
    status_is(8'h00);
    read_check(16'hfc00, 2);
    i_host.slow = 0;
    $display("t_abandon done");
  endtask : t_abandon

  // ****
  // main sequence
  // ****
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_idle();
    t_latch();
    t_write();
    t_abandon();
    give_verdict();
  end
endmodule : testbench

bind spi_eeprom_access_core spi_eeprom_access_core_assertions #(.WRITE_CYCLES(WRITE_CYCLES))
  i_chk (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
  .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe));
